// file: design/sfc_unit.sv
// shifter, condition flags, condition evaluator and address checks behind an Avalon slave
// What this block does
// - zero length: operand and carry unchanged
// - arithmetic right fills top with bit 31
// - arithmetic carry bit n-1; 32+ gives bit 31
// - logical right zero fill, carry bit n-1
// - logical 32+ gives zero; 33+ carry zero
// - logical left zero fill, carry bit 32-n
// - rotate wraps low bits, carry bit n-1
// - rotate 32 unchanged carry bit 31; wraps
// - unaligned word or halfword raises hard fault
// - program counter reads as address plus four
// - register branch and pop targets need bit 0; link bit 0 set
// - untouched flags keep their old values
// - negative and zero follow the result
// - carry from add, no borrow, or shift
// - overflow when sign of result is wrong
// - compares set flags but write no result
// - branch taken only when condition holds
// - simple conditions test a single flag
// - higher, lower-same, ge, lt compound forms
// - greater-than needs z clear; always always
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
module sfc_unit (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// core side
	output logic hard_fault_exception,
	output logic branch_taken
);
	typedef struct packed {
		logic [31:0] operand_a;
		logic [31:0] operand_b;
		logic [31:0] result;
		logic [3:0] program_status_flags;
		logic [31:0] instr_addr;
		logic [31:0] program_counter;
		logic [31:0] link_value;
		logic [31:0] next_pc;
		logic taken;
		logic fault;
		logic [31:0] readdata;
		logic waitreq;
	} sfc_state_t;

	sfc_state_t state_ff;
	sfc_state_t nxt_state;

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// barrel shifter: returns {carry, result}
	function automatic logic [32:0] shift(input sfc_pkg::sfc_op_t op, input logic [31:0] v,
		input logic [7:0] n, input logic cin);
		logic [4:0] k;
		logic [4:0] m;
		logic [63:0] w;
		logic [32:0] r;
		k = n[4:0] - 5'h01;
		m = 5'h00 - n[4:0];
		w = {v, v} >> n[4:0];
		r = {cin, v};
		if (n != 8'h00) begin
			unique case (op)
				sfc_pkg::OP_ARITH_SHIFT_RIGHT: begin
					if (n >= 8'h20) begin
						r = {v[31], {32{v[31]}}};
					end else begin
						r = {v[k], 32'($signed(v) >>> n[4:0])};
					end
				end
				sfc_pkg::OP_LOGIC_SHIFT_RIGHT: begin
					if (n == 8'h20) begin
						r = {v[31], 32'h0000_0000};
					end else if (n > 8'h20) begin
						r = 33'h0_0000_0000;
					end else begin
						r = {v[k], v >> n[4:0]};
					end
				end
				sfc_pkg::OP_LOGIC_SHIFT_LEFT: begin
					if (n == 8'h20) begin
						r = {v[0], 32'h0000_0000};
					end else if (n > 8'h20) begin
						r = 33'h0_0000_0000;
					end else begin
						r = {v[m], v << n[4:0]};
					end
				end
				sfc_pkg::OP_ROTATE_RIGHT: begin
					// multiples of 32 land on zero rotation, carry then is bit 31
					r = {w[31], w[31:0]};
				end
				default: begin
					r = {cin, v};
				end
			endcase
		end
		return r;
	endfunction

	// condition evaluation against n z c v
	function automatic logic cond_met(input logic [3:0] c, input logic [3:0] f);
		logic fn;
		logic fz;
		logic fc;
		logic fv;
		logic t;
		fn = f[3];
		fz = f[2];
		fc = f[1];
		fv = f[0];
		unique case (sfc_pkg::sfc_cond_t'(c))
			sfc_pkg::COND_EQUAL: t = fz;
			sfc_pkg::COND_NOT_EQUAL: t = !fz;
			sfc_pkg::COND_CARRY_SET: t = fc;
			sfc_pkg::COND_CARRY_CLEAR: t = !fc;
			sfc_pkg::COND_NEGATIVE: t = fn;
			sfc_pkg::COND_POSITIVE: t = !fn;
			sfc_pkg::COND_OVERFLOW: t = fv;
			sfc_pkg::COND_NO_OVERFLOW: t = !fv;
			sfc_pkg::COND_UNSIGNED_HIGHER: t = fc && !fz;
			sfc_pkg::COND_UNSIGNED_LOWER_SAME: t = !fc || fz;
			sfc_pkg::COND_SIGNED_GE: t = (fn == fv);
			sfc_pkg::COND_SIGNED_LT: t = (fn != fv);
			sfc_pkg::COND_SIGNED_GT: t = !fz && (fn == fv);
			sfc_pkg::COND_SIGNED_LE: t = fz || (fn != fv);
			sfc_pkg::COND_ALWAYS, sfc_pkg::COND_ALWAYS_ALT: t = 1'b1;
		endcase
		return t;
	endfunction

	// register read mux
	function automatic logic [31:0] read_reg(input sfc_state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			sfc_pkg::OFS_OPERAND_A: r = s.operand_a;
			sfc_pkg::OFS_OPERAND_B: r = s.operand_b;
			sfc_pkg::OFS_RESULT: r = s.result;
			sfc_pkg::OFS_FLAGS: r[sfc_pkg::FLAG_N_BIT -: 4] = s.program_status_flags;
			sfc_pkg::OFS_INSTR_ADDR: r = s.instr_addr;
			sfc_pkg::OFS_PC_OPERAND: r = s.program_counter;
			sfc_pkg::OFS_LINK: r = s.link_value;
			sfc_pkg::OFS_NEXT_PC: r = s.next_pc;
			sfc_pkg::OFS_STATUS: begin
				r[sfc_pkg::STAT_TAKEN_BIT] = s.taken;
				r[sfc_pkg::STAT_FAULT_BIT] = s.fault;
			end
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	always_comb begin
		logic [31:0] cmd;
		sfc_pkg::sfc_op_t op;
		logic flagset;
		logic [1:0] size;
		logic [32:0] sh;
		logic subtract;
		logic [31:0] bop;
		logic [32:0] sum;
		logic fn;
		logic fz;
		logic fc;
		logic fv;
		logic fault_evt;
		logic fault_clr;
		logic [31:0] target;
		cmd = 32'h0000_0000;
		op = sfc_pkg::OP_NONE;
		flagset = 1'b0;
		size = sfc_pkg::SIZE_BYTE;
		sh = 33'h0_0000_0000;
		subtract = 1'b0;
		bop = 32'h0000_0000;
		sum = 33'h0_0000_0000;
		fn = state_ff.program_status_flags[3];
		fz = state_ff.program_status_flags[2];
		fc = state_ff.program_status_flags[1];
		fv = state_ff.program_status_flags[0];
		fault_evt = 1'b0;
		fault_clr = 1'b0;
		target = 32'h0000_0000;
		nxt_state = state_ff;
		nxt_state.program_counter = state_ff.instr_addr + sfc_pkg::PC_READ_AHEAD;

		// one wait cycle: read data is prepared, the access completes the next edge
		if ((avs_read || avs_write) && state_ff.waitreq) begin
			nxt_state.waitreq = 1'b0;
			nxt_state.readdata = read_reg(state_ff, avs_address);
		end else begin
			// also recovers if a master ever withdraws a request mid-access
			nxt_state.waitreq = 1'b1;
		end

		if (avs_write && !state_ff.waitreq) begin
			unique case (avs_address)
				sfc_pkg::OFS_OPERAND_A: begin
					nxt_state.operand_a = merge(state_ff.operand_a, avs_writedata, avs_byteenable);
				end
				sfc_pkg::OFS_OPERAND_B: begin
					nxt_state.operand_b = merge(state_ff.operand_b, avs_writedata, avs_byteenable);
				end
				sfc_pkg::OFS_INSTR_ADDR: begin
					nxt_state.instr_addr = merge(state_ff.instr_addr, avs_writedata, avs_byteenable);
				end
				sfc_pkg::OFS_FLAGS: begin
					if (avs_byteenable[3]) begin
						{fn, fz, fc, fv} = avs_writedata[sfc_pkg::FLAG_N_BIT -: 4];
					end
				end
				sfc_pkg::OFS_STATUS: begin
					fault_clr = avs_byteenable[0] && avs_writedata[sfc_pkg::STAT_FAULT_BIT];
				end
				sfc_pkg::OFS_COMMAND: begin
					cmd = merge(32'h0000_0000, avs_writedata, avs_byteenable);
					op = sfc_pkg::sfc_op_t'(cmd[sfc_pkg::CMD_OP_LSB +: 4]);
					flagset = cmd[sfc_pkg::CMD_FLAGSET_BIT];
					size = cmd[sfc_pkg::CMD_SIZE_LSB +: 2];
					target = state_ff.operand_a;
					nxt_state.taken = 1'b0;
					unique case (op)
						sfc_pkg::OP_ARITH_SHIFT_RIGHT, sfc_pkg::OP_LOGIC_SHIFT_RIGHT,
						sfc_pkg::OP_LOGIC_SHIFT_LEFT, sfc_pkg::OP_ROTATE_RIGHT: begin
							sh = shift(op, state_ff.operand_a, state_ff.operand_b[7:0], fc);
							nxt_state.result = sh[31:0];
							if (flagset) begin
								fn = sh[31];
								fz = (sh[31:0] == 32'h0000_0000);
								fc = sh[32];
							end
						end
						sfc_pkg::OP_ADD, sfc_pkg::OP_SUB, sfc_pkg::OP_COMPARE,
						sfc_pkg::OP_COMPARE_NEGATIVE: begin
							// subtract as a plus inverted b plus one; carry means no borrow
							subtract = (op == sfc_pkg::OP_SUB) || (op == sfc_pkg::OP_COMPARE);
							bop = subtract ? ~state_ff.operand_b : state_ff.operand_b;
							sum = {1'b0, state_ff.operand_a} + {1'b0, bop} + {32'h0000_0000, subtract};
							if (op == sfc_pkg::OP_ADD || op == sfc_pkg::OP_SUB) begin
								nxt_state.result = sum[31:0];
							end
							if (flagset || op == sfc_pkg::OP_COMPARE ||
								op == sfc_pkg::OP_COMPARE_NEGATIVE) begin
								fn = sum[31];
								fz = (sum[31:0] == 32'h0000_0000);
								fc = sum[32];
								fv = (state_ff.operand_a[31] == bop[31]) &&
									(sum[31] != state_ff.operand_a[31]);
							end
						end
						sfc_pkg::OP_MOVE: begin
							nxt_state.result = state_ff.operand_a;
							if (flagset) begin
								fn = state_ff.operand_a[31];
								fz = (state_ff.operand_a == 32'h0000_0000);
							end
						end
						sfc_pkg::OP_COND_BRANCH: begin
							nxt_state.taken = cond_met(cmd[sfc_pkg::CMD_COND_LSB +: 4],
								state_ff.program_status_flags);
							nxt_state.next_pc = nxt_state.taken ? target :
								state_ff.instr_addr + sfc_pkg::SHORT_INSTR_BYTES;
						end
						sfc_pkg::OP_REGISTER_BRANCH, sfc_pkg::OP_REGISTER_BRANCH_WITH_LINK,
						sfc_pkg::OP_STACK_POP: begin
							// bit 0 only marks the instruction set; it never reaches the pc
							fault_evt = !target[0];
							nxt_state.taken = target[0];
							nxt_state.next_pc = {target[31:1], 1'b0};
							if (op == sfc_pkg::OP_REGISTER_BRANCH_WITH_LINK) begin
								nxt_state.link_value = (state_ff.instr_addr +
									sfc_pkg::SHORT_INSTR_BYTES) | 32'h0000_0001;
							end
						end
						sfc_pkg::OP_BRANCH_WITH_LINK: begin
							nxt_state.taken = 1'b1;
							nxt_state.next_pc = {target[31:1], 1'b0};
							nxt_state.link_value = (state_ff.instr_addr +
								sfc_pkg::LONG_INSTR_BYTES) | 32'h0000_0001;
						end
						sfc_pkg::OP_MEM_ACCESS: begin
							unique case (size)
								sfc_pkg::SIZE_BYTE: fault_evt = 1'b0;
								sfc_pkg::SIZE_HALF: fault_evt = target[0];
								sfc_pkg::SIZE_WORD, sfc_pkg::SIZE_MULTI: begin
									fault_evt = (target[1:0] != 2'h0);
								end
							endcase
						end
						default: begin
							nxt_state.taken = 1'b0;
						end
					endcase
				end
				default: begin
					nxt_state.taken = state_ff.taken;
				end
			endcase
		end

		nxt_state.program_status_flags = {fn, fz, fc, fv};
		// a new fault in the clearing cycle is kept
		nxt_state.fault = fault_evt || (state_ff.fault && !fault_clr);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_ff <= '{
				operand_a: sfc_pkg::RST_WORD,
				operand_b: sfc_pkg::RST_WORD,
				result: sfc_pkg::RST_WORD,
				program_status_flags: sfc_pkg::RST_FLAGS,
				instr_addr: sfc_pkg::RST_WORD,
				program_counter: sfc_pkg::PC_READ_AHEAD,
				link_value: sfc_pkg::RST_WORD,
				next_pc: sfc_pkg::RST_WORD,
				taken: 1'b0,
				fault: 1'b0,
				readdata: sfc_pkg::RST_WORD,
				waitreq: 1'b1
			};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign avs_readdata = state_ff.readdata;
	assign avs_waitrequest = state_ff.waitreq;
	assign hard_fault_exception = state_ff.fault;
	assign branch_taken = state_ff.taken;
endmodule

// file: design/sfc_pkg.sv
// shared constants and types for the shifter, flags and condition unit
package sfc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_OPERAND_A = 8'h00;
	localparam logic [7:0] OFS_OPERAND_B = 8'h04;
	localparam logic [7:0] OFS_COMMAND = 8'h08;
	localparam logic [7:0] OFS_RESULT = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_INSTR_ADDR = 8'h14;
	localparam logic [7:0] OFS_PC_OPERAND = 8'h18;
	localparam logic [7:0] OFS_LINK = 8'h1C;
	localparam logic [7:0] OFS_NEXT_PC = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;

	// command register fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_FLAGSET_BIT = 4;
	localparam int CMD_COND_LSB = 5;
	localparam int CMD_SIZE_LSB = 9;

	// flags register: n z c v in bits 31..28
	localparam int FLAG_N_BIT = 31;
	localparam int FLAG_Z_BIT = 30;
	localparam int FLAG_C_BIT = 29;
	localparam int FLAG_V_BIT = 28;

	// status register bits
	localparam int STAT_TAKEN_BIT = 0;
	localparam int STAT_FAULT_BIT = 1;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [3:0] RST_FLAGS = 4'h0;

	// address offsets of the program counter
	localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0004;
	localparam logic [31:0] SHORT_INSTR_BYTES = 32'h0000_0002;
	localparam logic [31:0] LONG_INSTR_BYTES = 32'h0000_0004;

	// opcodes written by software, so their codes are fixed
	typedef enum logic [3:0] {
		OP_ARITH_SHIFT_RIGHT = 4'h0,
		OP_LOGIC_SHIFT_RIGHT = 4'h1,
		OP_LOGIC_SHIFT_LEFT = 4'h2,
		OP_ROTATE_RIGHT = 4'h3,
		OP_ADD = 4'h4,
		OP_SUB = 4'h5,
		OP_COMPARE = 4'h6,
		OP_COMPARE_NEGATIVE = 4'h7,
		OP_MOVE = 4'h8,
		OP_COND_BRANCH = 4'h9,
		OP_REGISTER_BRANCH = 4'hA,
		OP_REGISTER_BRANCH_WITH_LINK = 4'hB,
		OP_BRANCH_WITH_LINK = 4'hC,
		OP_STACK_POP = 4'hD,
		OP_MEM_ACCESS = 4'hE,
		OP_NONE = 4'hF
	} sfc_op_t;

	typedef enum logic [3:0] {
		COND_EQUAL = 4'h0,
		COND_NOT_EQUAL = 4'h1,
		COND_CARRY_SET = 4'h2,
		COND_CARRY_CLEAR = 4'h3,
		COND_NEGATIVE = 4'h4,
		COND_POSITIVE = 4'h5,
		COND_OVERFLOW = 4'h6,
		COND_NO_OVERFLOW = 4'h7,
		COND_UNSIGNED_HIGHER = 4'h8,
		COND_UNSIGNED_LOWER_SAME = 4'h9,
		COND_SIGNED_GE = 4'hA,
		COND_SIGNED_LT = 4'hB,
		COND_SIGNED_GT = 4'hC,
		COND_SIGNED_LE = 4'hD,
		COND_ALWAYS = 4'hE,
		COND_ALWAYS_ALT = 4'hF
	} sfc_cond_t;

	// access sizes for the alignment check
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_MULTI = 2'h3;
endpackage

// file: verification/sfc_unit_chk.sv
// port assertions for the shifter, flags and condition unit
`timescale 1ns/100ps
module sfc_unit_chk (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// core side
	input wire logic hard_fault_exception,
	input wire logic branch_taken
);
	logic done;
	logic cmdw;
	logic clr;
	assign done = (avs_read || avs_write) && !avs_waitrequest;
	assign cmdw = done && avs_write && avs_address == sfc_pkg::OFS_COMMAND;
	assign clr = done && avs_write && avs_address == sfc_pkg::OFS_STATUS
		&& avs_writedata[1] && avs_byteenable[0];
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_WAIT_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	AST_WAIT_CAUSE: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("waitrequest dropped without a request");
	AST_RESET_STATE: assert property (disable iff (1'b0) reset |=> avs_waitrequest
		&& !hard_fault_exception && !branch_taken && avs_readdata == 32'h0)
		else $error("outputs not at reset state");
	AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read || avs_write))
		else $error("readdata changed between accesses");
	AST_FAULT_RISE: assert property ($rose(hard_fault_exception) |->
		$past(cmdw) || $past(cmdw, 2))
		else $error("fault raised without a command");
	AST_FAULT_FALL: assert property ($fell(hard_fault_exception) |->
		$past(clr) || $past(clr, 2))
		else $error("fault cleared without a clear write");
	AST_TAKEN_HOLD: assert property ($changed(branch_taken) |->
		$past(cmdw) || $past(cmdw, 2))
		else $error("branch_taken changed without a command");
endmodule

bind sfc_unit sfc_unit_chk sfc_unit_chk_inst (
	.clock(clock),
	.reset(reset),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.hard_fault_exception(hard_fault_exception),
	.branch_taken(branch_taken)
);

// file: verification/sfc_dec_mdl.sv
// decode stage model: avalon master issuing operands and commands
`timescale 1ns/100ps
module sfc_dec_mdl (
	// clock
	input wire logic clock,
	// avalon-mm master
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest
);
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
	end
	// entered just after a rising edge; one idle cycle after each access
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		// the request stands until the rising edge that samples waitrequest low
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// released data flips so a stale value is never mistaken for live
		avs_writedata <= ~d;
		@(posedge clock);
	endtask
endmodule

// file: verification/tb.sv
// self-checking bench for the shifter, flags and condition unit
`timescale 1ns/100ps
module tb;
	typedef struct packed {
		logic [3:0] fl;
		logic [3:0] op;
		logic fs;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] r;
		logic [3:0] f;
	} sfc_row_t;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic hard_fault_exception;
	logic branch_taken;
	int err_total = 0;
	int samples_checked = 0;
	logic [31:0] q;
	logic tk;
	logic hf;
	logic e;
	// flags before, op, flag-set, a, b, result, flags after
	sfc_row_t rows [20] = '{
		'{4'h3, 4'h0, 1'b1, 32'h80000010, 32'h4, 32'hF8000001, 4'h9},
		'{4'h0, 4'h0, 1'b1, 32'h80000000, 32'h28, 32'hFFFFFFFF, 4'hA},
		'{4'h2, 4'h0, 1'b1, 32'h5, 32'h0, 32'h5, 4'h2},
		'{4'h0, 4'h1, 1'b1, 32'h80000003, 32'h2, 32'h20000000, 4'h2},
		'{4'h0, 4'h1, 1'b1, 32'h80000000, 32'h20, 32'h0, 4'h6},
		'{4'h2, 4'h1, 1'b1, 32'hFFFFFFFF, 32'h21, 32'h0, 4'h4},
		'{4'h0, 4'h2, 1'b1, 32'h3, 32'h1F, 32'h80000000, 4'hA},
		'{4'h2, 4'h2, 1'b1, 32'hFFFFFFFF, 32'h21, 32'h0, 4'h4},
		'{4'h2, 4'h2, 1'b1, 32'h0, 32'h0, 32'h0, 4'h6},
		'{4'h2, 4'h3, 1'b1, 32'h13, 32'h4, 32'h30000001, 4'h0},
		'{4'h0, 4'h3, 1'b1, 32'h80000001, 32'h20, 32'h80000001, 4'hA},
		'{4'h0, 4'h3, 1'b1, 32'h3, 32'h21, 32'h80000001, 4'hA},
		'{4'h9, 4'h4, 1'b1, 32'hFFFFFFFF, 32'h1, 32'h0, 4'h6},
		'{4'h6, 4'h4, 1'b1, 32'h7FFFFFFF, 32'h1, 32'h80000000, 4'h9},
		'{4'h9, 4'h5, 1'b1, 32'h5, 32'h5, 32'h0, 4'h6},
		'{4'h0, 4'h5, 1'b1, 32'h80000000, 32'h1, 32'h7FFFFFFF, 4'h3},
		'{4'h3, 4'h6, 1'b1, 32'h3, 32'h5, 32'h7FFFFFFF, 4'h8},
		'{4'h9, 4'h7, 1'b1, 32'hFFFFFFFF, 32'h1, 32'h7FFFFFFF, 4'h6},
		'{4'hF, 4'h4, 1'b0, 32'h1, 32'h2, 32'h3, 4'hF},
		'{4'h3, 4'h8, 1'b1, 32'h0, 32'h0, 32'h0, 4'h7}
	};
	sfc_unit sfc_unit_inst (
		.clock(clock),
		.reset(reset),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.hard_fault_exception(hard_fault_exception),
		.branch_taken(branch_taken)
	);
	sfc_dec_mdl sfc_dec_mdl_inst (
		.clock(clock),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest)
	);
	initial begin
		forever #25 clock = ~clock;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
			err_total++;
		end
	endtask
	task automatic results();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		sfc_dec_mdl_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		sfc_dec_mdl_inst.xfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask
	// outputs settle a cycle after the command, so look mid-cycle later
	task automatic cmd(input logic [31:0] c);
		wr(sfc_pkg::OFS_COMMAND, c);
		repeat (2) @(posedge clock);
		@(negedge clock);
		tk = branch_taken;
		hf = hard_fault_exception;
		@(posedge clock);
	endtask
	function automatic logic cond_hold(input logic [3:0] c, input logic [3:0] f);
		logic n, z, k, v;
		{n, z, k, v} = f;
		case (c)
			4'h0: cond_hold = z;
			4'h1: cond_hold = !z;
			4'h2: cond_hold = k;
			4'h3: cond_hold = !k;
			4'h4: cond_hold = n;
			4'h5: cond_hold = !n;
			4'h6: cond_hold = v;
			4'h7: cond_hold = !v;
			4'h8: cond_hold = k && !z;
			4'h9: cond_hold = !k || z;
			4'hA: cond_hold = n == v;
			4'hB: cond_hold = n != v;
			4'hC: cond_hold = !z && n == v;
			4'hD: cond_hold = z || n != v;
			default: cond_hold = 1'b1;
		endcase
	endfunction
	initial begin
		repeat (40000) @(posedge clock);
		err_total++;
		results();
	end
	initial begin
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk({30'h0, hard_fault_exception, avs_waitrequest}, 32'h1);
		@(posedge clock);
		rd(sfc_pkg::OFS_PC_OPERAND, 32'h4);
		rd(sfc_pkg::OFS_FLAGS, 32'h0);
		foreach (rows[i]) begin
			wr(sfc_pkg::OFS_FLAGS, {rows[i].fl, 28'h0});
			wr(sfc_pkg::OFS_OPERAND_A, rows[i].a);
			wr(sfc_pkg::OFS_OPERAND_B, rows[i].b);
			cmd({27'h0, rows[i].fs, rows[i].op});
			rd(sfc_pkg::OFS_RESULT, rows[i].r);
			rd(sfc_pkg::OFS_FLAGS, {rows[i].f, 28'h0});
		end
		wr(8'h3C, 32'hFFFFFFFF);
		rd(8'h3C, 32'h0);
		rd(sfc_pkg::OFS_COMMAND, 32'h0);
		wr(sfc_pkg::OFS_OPERAND_A, 32'h1000);
		wr(sfc_pkg::OFS_INSTR_ADDR, 32'h200);
		rd(sfc_pkg::OFS_PC_OPERAND, 32'h204);
		for (int c = 0; c < 16; c++) begin
			for (int f = 0; f < 16; f++) begin
				wr(sfc_pkg::OFS_FLAGS, {f[3:0], 28'h0});
				cmd({23'h0, c[3:0], 5'h09});
				e = cond_hold(c[3:0], f[3:0]);
				chk({31'h0, tk}, {31'h0, e});
				rd(sfc_pkg::OFS_NEXT_PC, e ? 32'h1000 : 32'h202);
			end
		end
		rd(sfc_pkg::OFS_FLAGS, 32'hF0000000);
		// even target: the decode side breaks the bit 0 rule on purpose
		cmd(32'hA);
		chk({31'h0, hf}, 32'h1);
		rd(sfc_pkg::OFS_NEXT_PC, 32'h1000);
		wr(sfc_pkg::OFS_STATUS, 32'h2);
		wr(sfc_pkg::OFS_OPERAND_A, 32'h1001);
		cmd(32'hB);
		chk({31'h0, hf}, 32'h0);
		rd(sfc_pkg::OFS_LINK, 32'h203);
		cmd(32'hC);
		chk({31'h0, tk}, 32'h1);
		rd(sfc_pkg::OFS_LINK, 32'h205);
		for (int s = 0; s < 4; s++) begin
			for (int a = 0; a < 4; a++) begin
				wr(sfc_pkg::OFS_OPERAND_A, {30'h0, a[1:0]});
				cmd({21'h0, s[1:0], 9'h00E});
				e = (s == 1) ? a[0] : (s >= 2 && a[1:0] != 2'h0);
				chk({31'h0, hf}, {31'h0, e});
				wr(sfc_pkg::OFS_STATUS, 32'h2);
			end
		end
		// pop to an even address faults and is never taken
		wr(sfc_pkg::OFS_OPERAND_A, 32'h2);
		cmd(32'hD);
		chk({30'h0, hf, tk}, 32'h2);
		rd(sfc_pkg::OFS_NEXT_PC, 32'h2);
		// reset in mid-run while the fault still stands
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		chk({30'h0, hard_fault_exception, avs_waitrequest}, 32'h1);
		@(posedge clock);
		rd(sfc_pkg::OFS_FLAGS, 32'h0);
		rd(sfc_pkg::OFS_PC_OPERAND, 32'h4);
		results();
	end
endmodule
